// ===== osis_pkg.sv
// Timing, register map, states and command stream of the panel host sequencer.
`default_nettype none
package osis_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock rate and delays, each in its own unit.
  localparam int unsigned CLK_MHZ   = 200;
  localparam int unsigned US_PER_MS = 1000;
  localparam int unsigned T_VDD_MS  = 20;
  localparam int unsigned T_RST_US  = 3;
  localparam int unsigned T_VCC_US  = 100;
  localparam int unsigned T_ON_MS   = 100;
  localparam int unsigned T_OFF_MS  = 80;

  // Cycle counts; whole microseconds at this rate need no rounding.
  localparam logic [31:0] RST_CYC = 32'(T_RST_US * CLK_MHZ);
  localparam logic [31:0] VCC_CYC = 32'(T_VCC_US * CLK_MHZ);
  localparam logic [31:0] VDD_CYC = 32'(T_VDD_MS * US_PER_MS * CLK_MHZ);
  localparam logic [31:0] ON_CYC  = 32'(T_ON_MS * US_PER_MS * CLK_MHZ);
  localparam logic [31:0] OFF_CYC = 32'(T_OFF_MS * US_PER_MS * CLK_MHZ);

  // Serial clock half period in system cycles, giving 10 MHz.
  localparam int unsigned SCLK_HALF_CYC = 10;
  localparam logic [2:0]  TOP_BIT       = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map on the APB port, byte addresses.
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_RAW   = 8'h04;
  localparam logic [7:0]  ADDR_STAT  = 8'h08;
  localparam int unsigned CTL_ON     = 0;
  localparam int unsigned CTL_OFF    = 1;
  localparam int unsigned CTL_FILL   = 2;
  localparam int unsigned RAW_DC_BIT = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Command stream indices and bulk transfer sizes.
  localparam logic [5:0]  IDX_INIT     = 6'h00;
  localparam logic [5:0]  IDX_CLR_END  = 6'h24;
  localparam logic [5:0]  IDX_ON       = 6'h25;
  localparam logic [5:0]  IDX_FILL     = 6'h26;
  localparam logic [5:0]  IDX_FILL_END = 6'h2C;
  localparam logic [5:0]  IDX_OFF      = 6'h2D;
  localparam int unsigned RAM_ROWS     = 160;
  localparam int unsigned RAM_ROW_B    = 160;
  localparam int unsigned FILL_ROWS    = 64;
  localparam int unsigned FILL_ROW_B   = 128;
  // Two pixels per byte, so 160 by 160 bytes cover 320x160 nibbles.
  localparam logic [15:0] CLR_BYTES    = 16'(RAM_ROWS * RAM_ROW_B);
  localparam logic [15:0] FILL_BYTES   = 16'(FILL_ROWS * FILL_ROW_B);
  localparam logic [15:0] ONE_LEFT     = 16'h0001;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  BYTE_FULL    = 8'hFF;
  localparam logic        CMD          = 1'h0;
  localparam logic        DAT          = 1'h1;

  typedef enum logic [3:0] {
    ST_OFF, ST_VDDW, ST_RSTL, ST_VCCW, ST_ROM, ST_BULK,
    ST_DRAIN, ST_DONW, ST_READY, ST_RAW, ST_OFFW
  } osis_state_t;

  // Command stream: init block, RAM clear window, display on, fill window, off.
  function automatic logic [8:0] osis_rom(input logic [5:0] idx);
    logic [8:0] r;
    r = {CMD, BYTE_ZERO};
    case (idx)
      // Off, lock, remap, start line, offset, normal.
      6'h00: r = {CMD, 8'hAE};
      6'h01: r = {CMD, 8'hFD};
      6'h02: r = {DAT, 8'h12};
      6'h03: r = {CMD, 8'hA0};
      6'h04: r = {DAT, 8'h02};
      6'h05: r = {DAT, 8'h10};
      6'h06: r = {CMD, 8'hA1};
      6'h07: r = {DAT, 8'h00};
      6'h08: r = {CMD, 8'hA2};
      6'h09: r = {DAT, 8'h00};
      6'h0A: r = {CMD, 8'hA6};
      // Current reference, phases, clock, second precharge, gray table.
      6'h0B: r = {CMD, 8'hAD};
      6'h0C: r = {DAT, 8'h80};
      6'h0D: r = {CMD, 8'hB1};
      6'h0E: r = {DAT, 8'h74};
      6'h0F: r = {CMD, 8'hB3};
      6'h10: r = {DAT, 8'hB1};
      6'h11: r = {CMD, 8'hB6};
      6'h12: r = {DAT, 8'h08};
      6'h13: r = {CMD, 8'hB9};
      // Precharge, deselect level, contrast, multiplex ratio.
      6'h14: r = {CMD, 8'hBA};
      6'h15: r = {DAT, 8'h02};
      6'h16: r = {CMD, 8'hBB};
      6'h17: r = {DAT, 8'h07};
      6'h18: r = {CMD, 8'hBE};
      6'h19: r = {DAT, 8'h07};
      6'h1A: r = {CMD, 8'hC1};
      6'h1B: r = {DAT, 8'h4F};
      6'h1C: r = {CMD, 8'hCA};
      6'h1D: r = {DAT, 8'h7F};
      // Whole-RAM window then RAM write.
      6'h1E: r = {CMD, 8'h15};
      6'h1F: r = {DAT, 8'h00};
      6'h20: r = {DAT, 8'h4F};
      6'h21: r = {CMD, 8'h75};
      6'h22: r = {DAT, 8'h00};
      6'h23: r = {DAT, 8'h9F};
      6'h24: r = {CMD, 8'h5C};
      6'h25: r = {CMD, 8'hAF};
      // Visible window: four segments per column address.
      6'h26: r = {CMD, 8'h15};
      6'h27: r = {DAT, 8'h08};
      6'h28: r = {DAT, 8'h47};
      6'h29: r = {CMD, 8'h75};
      6'h2A: r = {DAT, 8'h00};
      6'h2B: r = {DAT, 8'h3F};
      6'h2C: r = {CMD, 8'h5C};
      6'h2D: r = {CMD, 8'hAE};
      default: r = {CMD, BYTE_ZERO};
    endcase
    return r;
  endfunction : osis_rom

endpackage : osis_pkg
`default_nettype wire

// ===== osis_spi_if.sv
// Byte handshake and serial pin signals between the sequencer and its shifter.
`default_nettype none
interface osis_spi_if;
  logic       valid;
  logic       ready;
  logic       busy;
  logic       dc;
  logic [7:0] dat;
  logic       sclk;
  logic       serial_data_in;
  logic       cs_n;
  logic       dc_pin;

  modport ctl (output valid, dc, dat, input ready, busy, sclk, serial_data_in, cs_n, dc_pin);
  modport shf (input valid, dc, dat, output ready, busy, sclk, serial_data_in, cs_n, dc_pin);
endinterface : osis_spi_if
`default_nettype wire

// ===== osis_spi_shift.sv
// Serial byte shifter: frames one byte with select, MSB first, clock idles low.
`default_nettype none
module osis_spi_shift
  import osis_pkg::*;
#(
  parameter int unsigned HALF = SCLK_HALF_CYC // System cycles per serial half period.
) (
  input wire logic clk,   // System clock.
  input wire logic rst,   // Asynchronous reset, active high.
  osis_spi_if.shf  sp     // Byte handshake and pin side.
);

  typedef enum logic {SH_IDLE, SH_SHIFT} osis_sh_t;

  osis_sh_t   st_reg;
  logic [7:0] sh_reg;
  logic [2:0] bit_reg;
  logic [7:0] div_reg;
  logic       sclk_reg;
  logic       cs_n_reg;
  logic       dc_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Decodes and pin outputs.
  wire       take     = sp.valid && (st_reg == SH_IDLE);
  wire       div_done = (div_reg == '0);
  wire       last_bit = (bit_reg == '0);
  wire [7:0] div_load = 8'(HALF - 1);

  assign sp.ready  = (st_reg == SH_IDLE);
  assign sp.busy   = (st_reg != SH_IDLE);
  assign sp.sclk   = sclk_reg;
  assign sp.serial_data_in   = sh_reg[TOP_BIT];
  assign sp.cs_n   = cs_n_reg;
  assign sp.dc_pin = dc_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Select stays low for the whole byte and D/C is held until it rises, so the
  // panel sees D/C steady on the eighth rising edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg   <= SH_IDLE;
      sh_reg   <= '0;
      bit_reg  <= '0;
      div_reg  <= '0;
      sclk_reg <= 1'h0;
      cs_n_reg <= 1'h1;
      dc_reg   <= 1'h0;
    end else if (take) begin
      st_reg   <= SH_SHIFT;
      sh_reg   <= sp.dat;
      dc_reg   <= sp.dc;
      cs_n_reg <= 1'h0;
      bit_reg  <= TOP_BIT;
      div_reg  <= div_load;
    end else if (st_reg == SH_SHIFT) begin
      div_reg <= div_done ? div_load : div_reg - 8'h01;
      if (div_done && !sclk_reg) begin
        sclk_reg <= 1'h1;
      end else if (div_done) begin
        sclk_reg <= 1'h0;
        bit_reg  <= bit_reg - 3'h1;
        sh_reg   <= {sh_reg[6:0], 1'h0};
        // Select rises with the last falling edge, ending the frame.
        if (last_bit) begin
          cs_n_reg <= 1'h1;
          st_reg   <= SH_IDLE;
        end
      end
    end
  end

endmodule : osis_spi_shift
`default_nettype wire

// ===== osis_top.sv
// Host controller that powers up, initialises, fills and powers down the panel module.
//
// Register access over APB and the register offsets are this design's own decisions.
`default_nettype none
module osis_top
  import osis_pkg::*;
#(
  parameter logic [31:0] VDD_WAIT  = VDD_CYC,      // Logic supply settle before reset.
  parameter logic [31:0] VCC_WAIT  = VCC_CYC,      // Panel supply settle before init.
  parameter logic [31:0] ON_WAIT   = ON_CYC,       // Display-on to drivers running.
  parameter logic [31:0] OFF_WAIT  = OFF_CYC,      // Panel supply off to logic off.
  parameter logic [15:0] CLR_CNT   = CLR_BYTES,    // Zero bytes that clear the whole RAM.
  parameter logic [15:0] FILL_CNT  = FILL_BYTES,   // Full bytes that light the window.
  parameter int unsigned SCLK_HALF = SCLK_HALF_CYC // Serial clock half period.
) (
  input  wire logic        CLK,                  // System clock, 200 MHz.
  input  wire logic        RST,                  // Asynchronous reset, active high.
  input  wire logic        PSEL,                 // APB select.
  input  wire logic        PENABLE,              // APB access phase.
  input  wire logic        PWRITE,               // APB write when high.
  input  wire logic [7:0]  PADDR,                // APB byte address.
  input  wire logic [31:0] PWDATA,               // APB write data.
  output logic      [31:0] PRDATA,               // APB read data.
  output logic             PREADY,               // APB ready, one wait state.
  output logic             PSLVERR,              // APB error on unmapped address.
  output logic             CS_N,                 // Panel chip select, active low.
  output logic             DC,                   // Low command, high data.
  output logic             SCLK,                 // Serial clock on data pin 0.
  output logic             SERIAL_DATA_IN_D1,    // Serial data on data pin 1.
  output logic             SERIAL_DATA_IN_D2,    // Serial data on data pin 2.
  output logic             HARDWARE_RESET_IN_N,  // Panel reset, active low.
  output logic             VCC_EN,               // Panel drive supply enable.
  output logic             VDD_EN,               // Panel logic supply enable.
  output logic             BUS_SELECT_LOW_BIT,   // Interface select, held low.
  output logic             BUS_SELECT_HIGH_BIT,  // Interface select, held low.
  output logic [1:0]       RW_RD,                // Parallel strobes, held low.
  output logic [4:0]       DATA_UPPER            // Unused data pins 3 to 7, held low.
);

  osis_spi_if spi ();

  osis_state_t state_reg, state_next;
  logic [5:0]  idx_reg, idx_next;
  logic [5:0]  last_reg, last_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        fill_reg, fill_next;
  logic [31:0] tmr_reg, tmr_next;
  logic        vdd_reg, vdd_next;
  logic        vcc_reg, vcc_next;
  logic        res_n_reg, res_n_next;
  logic [8:0]  raw_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        cs_n_reg, dc_reg, sclk_reg, sd1_reg, sd2_reg;
  logic [8:0]  tie_reg;

  osis_spi_shift #(
    .HALF (SCLK_HALF)
  ) u_shift (
    .clk (CLK),
    .rst (RST),
    .sp  (spi.shf)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode. A write lands only on the edge that also samples PREADY high.
  wire apb_acc   = PSEL && PENABLE && pready_reg;
  wire hit_ctrl  = (PADDR == ADDR_CTRL);
  wire hit_raw   = (PADDR == ADDR_RAW);
  wire hit_stat  = (PADDR == ADDR_STAT);
  wire mapped    = hit_ctrl || hit_raw || hit_stat;
  wire wr_ctrl   = apb_acc && PWRITE && hit_ctrl;
  wire wr_raw    = apb_acc && PWRITE && hit_raw;
  wire cmd_on    = wr_ctrl && PWDATA[CTL_ON];
  wire cmd_off   = wr_ctrl && PWDATA[CTL_OFF];
  wire cmd_fill  = wr_ctrl && PWDATA[CTL_FILL];
  wire disp_on   = (state_reg == ST_READY);

  // Status word: state, serial busy, supplies, reset pin, display running.
  wire [31:0] stat_word = {23'h000000, disp_on, res_n_reg, vcc_reg, vdd_reg,
                           spi.busy, state_reg};
  wire [31:0] rd_mux    = hit_raw  ? {23'h000000, raw_reg} :
                          hit_stat ? stat_word : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte source: stream table, bulk pixel bytes or the software raw byte.
  wire [8:0] rom_word  = osis_rom(idx_reg);
  wire [7:0] bulk_byte = fill_reg ? BYTE_FULL : BYTE_ZERO;
  wire       in_rom    = (state_reg == ST_ROM);
  wire       in_bulk   = (state_reg == ST_BULK);
  wire       in_raw    = (state_reg == ST_RAW);
  wire       spi_take  = spi.valid && spi.ready;
  wire       tmr_done  = (tmr_reg == '0);
  wire       at_last   = (idx_reg == last_reg);
  wire       bulk_end  = (cnt_reg == ONE_LEFT);

  assign spi.valid = in_rom || in_bulk || in_raw;
  // Pixel bytes are always data; stream and raw bytes carry their own mark.
  assign spi.dc    = in_bulk ? DAT : (in_raw ? raw_reg[RAW_DC_BIT] : rom_word[RAW_DC_BIT]);
  assign spi.dat   = in_bulk ? bulk_byte : (in_raw ? raw_reg[7:0] : rom_word[7:0]);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer. Requests that do not fit the current state are ignored, which
  // keeps the supply order safe whatever software writes.
  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    last_next  = last_reg;
    cnt_next   = cnt_reg;
    fill_next  = fill_reg;
    tmr_next   = tmr_done ? tmr_reg : tmr_reg - 32'h1;
    vdd_next   = vdd_reg;
    vcc_next   = vcc_reg;
    res_n_next = res_n_reg;
    case (state_reg)
      ST_OFF: if (cmd_on) begin
        vdd_next   = 1'h1;
        tmr_next   = VDD_WAIT;
        state_next = ST_VDDW;
      end
      ST_VDDW: if (tmr_done) begin
        res_n_next = 1'h0;
        tmr_next   = RST_CYC;
        state_next = ST_RSTL;
      end
      // Panel supply comes up with the reset release, past 3 us of low.
      ST_RSTL: if (tmr_done) begin
        res_n_next = 1'h1;
        vcc_next   = 1'h1;
        tmr_next   = VCC_WAIT;
        state_next = ST_VCCW;
      end
      ST_VCCW: if (tmr_done) begin
        idx_next   = IDX_INIT;
        last_next  = IDX_CLR_END;
        state_next = ST_ROM;
      end
      ST_ROM: if (spi_take) begin
        idx_next = idx_reg + 6'h01;
        if (at_last && idx_reg == IDX_CLR_END) begin
          fill_next  = 1'h0;
          cnt_next   = CLR_CNT;
          state_next = ST_BULK;
        end else if (at_last && idx_reg == IDX_FILL_END) begin
          fill_next  = 1'h1;
          cnt_next   = FILL_CNT;
          state_next = ST_BULK;
        end else if (at_last) begin
          state_next = ST_DRAIN;
        end
      end
      ST_BULK: if (spi_take) begin
        cnt_next = cnt_reg - 16'h0001;
        if (bulk_end && fill_reg) begin
          state_next = ST_READY;
        end else if (bulk_end) begin
          idx_next   = IDX_ON;
          last_next  = IDX_ON;
          state_next = ST_ROM;
        end
      end
      // Delays are timed from the end of the byte, not from its hand-off.
      ST_DRAIN: if (!spi.busy && last_reg == IDX_ON) begin
        tmr_next   = ON_WAIT;
        state_next = ST_DONW;
      end else if (!spi.busy) begin
        vcc_next   = 1'h0;
        tmr_next   = OFF_WAIT;
        state_next = ST_OFFW;
      end
      ST_DONW: if (tmr_done) begin
        state_next = ST_READY;
      end
      ST_READY: if (cmd_off) begin
        idx_next   = IDX_OFF;
        last_next  = IDX_OFF;
        state_next = ST_ROM;
      end else if (cmd_fill) begin
        idx_next   = IDX_FILL;
        last_next  = IDX_FILL_END;
        state_next = ST_ROM;
      end else if (wr_raw) begin
        state_next = ST_RAW;
      end
      ST_RAW: if (spi_take) begin
        state_next = ST_READY;
      end
      ST_OFFW: if (tmr_done) begin
        vdd_next   = 1'h0;
        res_n_next = 1'h0;
        state_next = ST_OFF;
      end
      default: state_next = ST_OFF;
    endcase
  end

  // Sequencer state.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_OFF;
      idx_reg   <= '0;
      last_reg  <= '0;
      cnt_reg   <= '0;
      fill_reg  <= 1'h0;
      tmr_reg   <= '0;
      vdd_reg   <= 1'h0;
      vcc_reg   <= 1'h0;
      res_n_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      last_reg  <= last_next;
      cnt_reg   <= cnt_next;
      fill_reg  <= fill_next;
      tmr_reg   <= tmr_next;
      vdd_reg   <= vdd_next;
      vcc_reg   <= vcc_next;
      res_n_reg <= res_n_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave registers. Ready is registered, so every access sees one wait state.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      raw_reg     <= '0;
      pready_reg  <= 1'h0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'h0;
    end else begin
      if (wr_raw && state_reg == ST_READY) begin
        raw_reg <= PWDATA[RAW_DC_BIT:0];
      end
      pready_reg  <= PSEL && PENABLE && !pready_reg;
      prdata_reg  <= rd_mux;
      pslverr_reg <= !mapped;
    end
  end

  // Pin flops: serial pins pass one register so every output leaves a flop.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cs_n_reg <= 1'h1;
      dc_reg   <= 1'h0;
      sclk_reg <= 1'h0;
      sd1_reg  <= 1'h0;
      sd2_reg  <= 1'h0;
      tie_reg  <= '0;
    end else begin
      cs_n_reg <= spi.cs_n;
      dc_reg   <= spi.dc_pin;
      sclk_reg <= spi.sclk;
      sd1_reg  <= spi.serial_data_in;
      sd2_reg  <= spi.serial_data_in;
      tie_reg  <= '0;
    end
  end

  assign PRDATA              = prdata_reg;
  assign PREADY              = pready_reg;
  assign PSLVERR             = pslverr_reg;
  assign CS_N                = cs_n_reg;
  assign DC                  = dc_reg;
  assign SCLK                = sclk_reg;
  assign SERIAL_DATA_IN_D1   = sd1_reg;
  assign SERIAL_DATA_IN_D2   = sd2_reg;
  assign HARDWARE_RESET_IN_N = res_n_reg;
  assign VCC_EN              = vcc_reg;
  assign VDD_EN              = vdd_reg;
  assign BUS_SELECT_LOW_BIT  = tie_reg[0];
  assign BUS_SELECT_HIGH_BIT = tie_reg[1];
  assign RW_RD               = tie_reg[3:2];
  assign DATA_UPPER          = tie_reg[8:4];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the pins and the sequencer.
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  cs_frame_a: assert property ($rose(SCLK) |-> !CS_N)
    else $error("Serial clock rose with select high.");
  res_pulse_a: assert property ($rose(HARDWARE_RESET_IN_N) |->
      !$past(HARDWARE_RESET_IN_N, RST_CYC) && VDD_EN)
    else $error("Reset pulse shorter than its minimum.");
  tie_low_a: assert property ({BUS_SELECT_LOW_BIT, BUS_SELECT_HIGH_BIT, RW_RD,
      DATA_UPPER} == '0)
    else $error("A strapped pin is not low.");
  serial_data_in_pair_a: assert property (SERIAL_DATA_IN_D1 == SERIAL_DATA_IN_D2)
    else $error("Serial data pins differ.");
  dc_steady_a: assert property (!CS_N && $past(!CS_N) |-> $stable(DC))
    else $error("D/C moved inside a byte.");
  vcc_order_a: assert property ($rose(VCC_EN) |->
      !$past(HARDWARE_RESET_IN_N, RST_CYC))
    else $error("Panel supply on too soon after reset.");
  init_start_a: assert property (state_reg == ST_VCCW ##1 state_reg == ST_ROM |->
      idx_reg == IDX_INIT)
    else $error("Init stream did not start at its head.");
  don_wait_a: assert property (state_reg == ST_DRAIN && !spi.busy && last_reg == IDX_ON
      |=> state_reg == ST_DONW && tmr_reg == ON_WAIT)
    else $error("Display-on wait not started.");
  off_order_a: assert property ($fell(VDD_EN) |-> !VCC_EN && !$past(VCC_EN, 2))
    else $error("Logic supply dropped before panel supply.");
  bulk_data_a: assert property (in_bulk && spi_take |-> spi.dc == DAT)
    else $error("Pixel byte not marked as data.");
  apb_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("APB ready missing after one wait state.");

  reach_ready_c: cover property (state_reg == ST_DONW ##1 state_reg == ST_READY);
  fill_done_c:   cover property (in_bulk && fill_reg && bulk_end && spi_take);
  raw_sent_c:    cover property (in_raw && spi_take);
  power_off_c:   cover property ($fell(VDD_EN));

endmodule : osis_top
`default_nettype wire

// ===== osis_panel_model.sv
// Behavioural panel that gathers each serial byte with its D/C flag.
`default_nettype none
module osis_panel_model (
  input wire logic sclk,  // Serial clock.
  input wire logic serial_data_in,  // Serial data, both data pins together.
  input wire logic cs_n,  // Select, active low.
  input wire logic dc,    // Low command, high data.
  input wire logic res_n  // Reset, active low.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] rx[$];  // Received {dc, byte}.
  logic [7:0] sh;
  int         n;
  // A new frame or a panel reset drops any partial byte from an earlier one.
  always @(negedge cs_n or negedge res_n) n = 0;
  // MSB first on rising clock; D/C taken with the last bit; ignored in reset.
  always @(posedge sclk) if (!cs_n && res_n) begin
    sh = {sh[6:0], serial_data_in};
    n++;
    if (n == 8) rx.push_back({dc, sh});
  end
endmodule : osis_panel_model
`default_nettype wire

// ===== osis_top_tb.sv
// Self-checking bench for the panel host sequencer.
`default_nettype none
module osis_top_tb import osis_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] OFW = 32'h28;
  // Shortened bulk counts keep the run short; the full counts are checked as constants.
  localparam int NCLR = 160;
  localparam int NFIL = 128;
  logic clk, rst, psel, pen, pwr, rdy, err, cs_n, dc, sclk, d1, d2, res_n, vcc, vdd, se;
  logic [7:0]  addr;
  logic [31:0] wd, prd, rd;
  wire  [8:0]  tie;
  logic [8:0]  v, e;
  logic [8:0]  tb[46] = '{9'h0AE, 9'h0FD, 9'h112, 9'h0A0, 9'h102, 9'h110, 9'h0A1, 9'h100,
    9'h0A2, 9'h100, 9'h0A6, 9'h0AD, 9'h180, 9'h0B1, 9'h174, 9'h0B3, 9'h1B1, 9'h0B6, 9'h108,
    9'h0B9, 9'h0BA, 9'h102, 9'h0BB, 9'h107, 9'h0BE, 9'h107, 9'h0C1, 9'h14F, 9'h0CA, 9'h17F,
    9'h015, 9'h100, 9'h14F, 9'h075, 9'h100, 9'h19F, 9'h05C, 9'h0AF, 9'h015, 9'h108, 9'h147,
    9'h075, 9'h100, 9'h13F, 9'h05C, 9'h1FF};
  int fails, compares, seed, i, j, k, n, nl, b, hi;
  osis_top #(.VDD_WAIT(32'h32), .VCC_WAIT(32'h14), .ON_WAIT(32'h28), .OFF_WAIT(OFW),
    .SCLK_HALF(2), .CLR_CNT(16'(NCLR)), .FILL_CNT(16'(NFIL))) osis_top_i (.CLK(clk),
    .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(addr), .PWDATA(wd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
    .CS_N(cs_n), .DC(dc), .SCLK(sclk), .SERIAL_DATA_IN_D1(d1), .SERIAL_DATA_IN_D2(d2),
    .HARDWARE_RESET_IN_N(res_n), .VCC_EN(vcc), .VDD_EN(vdd), .BUS_SELECT_LOW_BIT(tie[0]),
    .BUS_SELECT_HIGH_BIT(tie[1]), .RW_RD(tie[3:2]), .DATA_UPPER(tie[8:4]));
  osis_panel_model osis_panel_model_i (.sclk(sclk), .serial_data_in(d1 & d2), .cs_n(cs_n), .dc(dc),
    .res_n(res_n));
  // Cycles since select last rose, to time the display-on wait from the pins.
  always @(posedge clk) hi <= cs_n ? hi + 1 : 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, bus cycle, polling and verdict.
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
    compares++;
    if (s !== ex) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, s);
    end
  endtask : chk
  task automatic stop_test();
    $display("Compares %0d, fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // Request holds until the edge that samples ready; one idle cycle avoids double drives.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwr  <= w;
    addr <= a;
    wd   <= d;
    @(posedge clk);
    pen <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (rdy === 1'h1) break;
    end
    rd = prd;
    se = err;
    psel <= 1'h0;
    pen  <= 1'h0;
    @(posedge clk);
    if (k == 50) begin
      fails++;
      stop_test();
    end
  endtask : apb
  task automatic wready();
    // Ready with the shifter idle, so the last byte has reached the panel.
    for (j = 0; j < 5000; j++) begin
      apb(1'h0, ADDR_STAT, 32'h0);
      if (rd[4:0] === 5'h08) break;
    end
    if (j == 5000) begin
      fails++;
      stop_test();
    end
  endtask : wready
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // Main sequence: reset, refusals, power-on, raw bytes, fill, power-off.
  initial begin
    seed = 32'hBECE72AE;
    {rst, psel, pen, pwr, addr, wd} = {1'h1, 43'h0};
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    apb(1'h0, ADDR_STAT, 32'h0);
    chk("stat", 32'h0, rd);
    apb(1'h0, 8'h0C, 32'h0);
    chk("slverr", 32'h1, 32'(se));
    apb(1'h1, ADDR_RAW, 32'h1AE);
    apb(1'h1, ADDR_CTRL, 32'h1);
    {n, nl} = 0;
    for (i = 0; i < 5000 && vcc !== 1'h1; i++) begin
      @(posedge clk);
      n += 32'(vdd);
      nl += 32'(vdd & !res_n);
    end
    chk("onwait", 32'h32 + RST_CYC + 2, n);
    chk("rstlow", 32'h1, 32'(nl > RST_CYC));
    chk("rsthi", 32'h1, 32'(res_n));
    wready();
    chk("ready", 32'h1, 32'(rd[8]));
    chk("donwait", 32'h1, 32'(hi > 32'h28));
    chk("clrlen", 32'd25600, 32'(CLR_BYTES));
    chk("fillen", 32'd8192, 32'(FILL_BYTES));
    chk("nbytes", 38 + NCLR, osis_panel_model_i.rx.size());
    for (i = 0; i < 38 + NCLR; i++) begin
      e = i < 37 ? tb[i] : (i == 37 + NCLR ? tb[37] : 9'h100);
      chk("init", e, osis_panel_model_i.rx[i]);
    end
    chk("ties", 32'h0, tie);
    $display("Test power-on done");
    repeat (4) begin
      v = 9'($random(seed));
      apb(1'h1, ADDR_RAW, {23'h0, v});
      wready();
      chk("raw", v, osis_panel_model_i.rx[$]);
    end
    b = osis_panel_model_i.rx.size();
    apb(1'h1, ADDR_CTRL, 32'h4);
    wready();
    chk("nfill", b + 7 + NFIL, osis_panel_model_i.rx.size());
    for (i = 0; i < 7 + NFIL; i++) begin
      chk("fill", tb[38 + (i < 7 ? i : 7)], osis_panel_model_i.rx[b + i]);
    end
    $display("Test fill done");
    apb(1'h1, ADDR_CTRL, 32'h2);
    n = 0;
    for (i = 0; i < 20000 && vdd !== 1'h0; i++) begin
      @(posedge clk);
      n += 32'(vdd & !vcc);
    end
    chk("offwait", OFW + 1, n);
    chk("offcmd", 32'h0AE, osis_panel_model_i.rx[$]);
    $display("Test power-off done");
    stop_test();
  end
endmodule : osis_top_tb
`default_nettype wire
